//--- rtl/src_sleep_reset_ctrl.sv
`timescale 1ns/10ps
module src_sleep_reset_ctrl (
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_resetn,
	input  wire logic                       i_rst_pin,
	input  wire logic                       i_rst_pin_disable,
	input  wire logic                       i_rst_pin_out,
	input  wire logic                       i_rst_pin_oe,
	input  wire logic                       i_sleep_enable,
	input  wire logic                       i_sleep_req,
	input  wire logic [1:0]                 i_sleep_mode,
	input  wire logic                       i_irq,
	input  wire logic [src_pkg::GPIO_W-1:0] i_gpio_out,
	input  wire logic [src_pkg::GPIO_W-1:0] i_gpio_oe,
	output logic                            o_sys_rstn,
	output logic                            o_cpu_clk_en,
	output logic                            o_mem_clk_en,
	output logic                            o_timer_clk_en,
	output logic                            o_adc_clk_en,
	output logic                            o_acmp_clk_en,
	output logic                            o_irq_clk_en,
	output logic                            o_io_clk_en,
	output logic                            o_sleeping,
	output logic                            o_wake,
	output logic [src_pkg::GPIO_W-1:0]      o_six_general_io_lines,
	output logic [src_pkg::GPIO_W-1:0]      o_six_general_io_lines_oe,
	output logic                            o_rst_pin_io_out,
	output logic                            o_rst_pin_io_oe
);

	// ---------------------------------------------------------------
	// reset pin filtering
	// ---------------------------------------------------------------
	logic                          pin_level;
	logic [src_pkg::RST_CNT_W-1:0] low_cnt_q;
	logic                          pin_rst_q;
	logic                          pin_asyn_n;

	src_sync u_pin_sync (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_async   (i_rst_pin),
		.o_level   (pin_level)
	);

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			low_cnt_q <= src_pkg::RST_CNT_ZERO;
		end else if (i_rst_pin_disable || pin_level) begin
			low_cnt_q <= src_pkg::RST_CNT_ZERO;
		end else if (low_cnt_q != src_pkg::RST_CNT_MAX) begin
			low_cnt_q <= low_cnt_q + src_pkg::RST_CNT_ONE;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			// starts asserted so core reset waits for a clean filter
			pin_rst_q <= 1'b1;
		end else begin
			// held low the full minimum length with the pin function enabled
			pin_rst_q <= !i_rst_pin_disable && (low_cnt_q == src_pkg::RST_CNT_MAX);
		end
	end

	// clockless path: the raw pin acts directly once it is a reset pin
	assign pin_asyn_n = i_rst_pin || i_rst_pin_disable;

	// ---------------------------------------------------------------
	// combined reset, asserted asynchronously, released synchronously
	// ---------------------------------------------------------------
	logic rst_any_n;
	logic rst_s1_q;

	// unless i_rst_pin_disable is set, any raw pin dip resets at once; pulses below the minimum may reset too
	assign rst_any_n = i_resetn && pin_asyn_n;

	// two flops so core reset always releases on a clean clock edge
	always_ff @(posedge i_sys_clk or negedge rst_any_n) begin
		if (!rst_any_n) begin
			rst_s1_q   <= 1'b0;
			o_sys_rstn <= 1'b0;
		end else begin
			rst_s1_q   <= !pin_rst_q;
			o_sys_rstn <= rst_s1_q && !pin_rst_q;
		end
	end

	// ---------------------------------------------------------------
	// io lines: floated while any reset is active
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge rst_any_n) begin
		if (!rst_any_n) begin
			o_six_general_io_lines    <= '0;
			o_six_general_io_lines_oe <= '0;
			o_rst_pin_io_out          <= 1'b0;
			o_rst_pin_io_oe           <= 1'b0;
		end else if (!o_sys_rstn || pin_rst_q) begin
			o_six_general_io_lines    <= '0;
			o_six_general_io_lines_oe <= '0;
			o_rst_pin_io_out          <= 1'b0;
			o_rst_pin_io_oe           <= 1'b0;
		end else begin
			o_six_general_io_lines    <= i_gpio_out;
			o_six_general_io_lines_oe <= i_gpio_oe;
			o_rst_pin_io_out          <= i_rst_pin_disable && i_rst_pin_out;
			o_rst_pin_io_oe           <= i_rst_pin_disable && i_rst_pin_oe;
		end
	end

	// ---------------------------------------------------------------
	// sleep sequencer
	// ---------------------------------------------------------------
	src_pkg::src_state_e state_q;
	src_pkg::src_mode_e  mode_q;
	logic                sleep_take;

	function automatic logic mode_legal(input logic [1:0] m);
		mode_legal = (m == src_pkg::SRC_MODE_IDLE) || (m == src_pkg::SRC_MODE_ADC_QUIET) ||
			(m == src_pkg::SRC_MODE_PWR_DOWN);
	endfunction

	// software request seen in run with a legal mode
	assign sleep_take = (state_q == src_pkg::SRC_ST_RUN) && i_sleep_enable && i_sleep_req &&
		mode_legal(i_sleep_mode);

	always_ff @(posedge i_sys_clk or negedge o_sys_rstn) begin
		if (!o_sys_rstn) begin
			state_q <= src_pkg::SRC_ST_RUN;
			mode_q  <= src_pkg::SRC_MODE_IDLE;
		end else begin
			case (state_q)
				src_pkg::SRC_ST_RUN: begin
					if (sleep_take) begin
						state_q <= src_pkg::SRC_ST_SLEEP;
						mode_q  <= src_pkg::src_mode_e'(i_sleep_mode);
					end
				end
				src_pkg::SRC_ST_SLEEP: begin
					// i_irq is sampled on this clock; a wake level must stand until o_wake
					if (i_irq) begin
						state_q <= src_pkg::SRC_ST_WAKE;
					end
				end
				src_pkg::SRC_ST_WAKE: begin
					state_q <= src_pkg::SRC_ST_RUN;
				end
				default: begin
					state_q <= src_pkg::SRC_ST_RUN;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// clock gating per mode
	// ---------------------------------------------------------------
	logic asleep;
	logic idle_m;
	logic adcq_m;
	logic pdn_m;
	logic run_cpu;
	logic run_mem;
	logic run_timer;
	logic run_adc;
	logic run_acmp;
	logic run_irq;
	logic run_io;

	assign asleep = (state_q == src_pkg::SRC_ST_SLEEP);
	assign idle_m = asleep && (mode_q == src_pkg::SRC_MODE_IDLE);
	assign adcq_m = asleep && (mode_q == src_pkg::SRC_MODE_ADC_QUIET);
	assign pdn_m  = asleep && (mode_q == src_pkg::SRC_MODE_PWR_DOWN);

	// which units keep their clock in each mode
	assign run_cpu   = !(idle_m || adcq_m || pdn_m);
	assign run_mem   = !(adcq_m || pdn_m);
	assign run_timer = !(adcq_m || pdn_m);
	assign run_adc   = !pdn_m;
	assign run_acmp  = !(adcq_m || pdn_m);
	assign run_irq   = !pdn_m;
	assign run_io    = !(adcq_m || pdn_m);

	always_ff @(posedge i_sys_clk or negedge o_sys_rstn) begin
		if (!o_sys_rstn) begin
			o_cpu_clk_en   <= 1'b1;
			o_mem_clk_en   <= 1'b1;
			o_timer_clk_en <= 1'b1;
			o_adc_clk_en   <= 1'b1;
			o_acmp_clk_en  <= 1'b1;
			o_irq_clk_en   <= 1'b1;
			o_io_clk_en    <= 1'b1;
		end else begin
			o_cpu_clk_en   <= run_cpu;
			o_mem_clk_en   <= run_mem;
			o_timer_clk_en <= run_timer;
			o_adc_clk_en   <= run_adc;
			o_acmp_clk_en  <= run_acmp;
			o_irq_clk_en   <= run_irq;
			o_io_clk_en    <= run_io;
		end
	end

	always_ff @(posedge i_sys_clk or negedge o_sys_rstn) begin
		if (!o_sys_rstn) begin
			o_sleeping <= 1'b0;
			o_wake     <= 1'b0;
		end else begin
			o_sleeping <= asleep || sleep_take;
			o_wake     <= asleep && i_irq;
		end
	end

endmodule

//--- common/src_pkg.sv
package src_pkg;

	// ---------------------------------------------------------------
	// power-saving modes
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_MODE_IDLE      = 2'h0,
		SRC_MODE_ADC_QUIET = 2'h1,
		SRC_MODE_PWR_DOWN  = 2'h3
	} src_mode_e;

	// ---------------------------------------------------------------
	// sequencer states, gray along run -> sleep -> wake
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_ST_RUN   = 2'h0,
		SRC_ST_SLEEP = 2'h1,
		SRC_ST_WAKE  = 2'h3
	} src_state_e;

	// ---------------------------------------------------------------
	// widths and timing
	// ---------------------------------------------------------------
	localparam int unsigned GPIO_W          = 6;
	localparam int unsigned CLK_PERIOD_NS   = 20;
	localparam int unsigned RST_MIN_PULSE_NS = 2500;
	localparam int unsigned RST_MIN_CYCLES  = (RST_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RST_CNT_W       = 8;
	localparam logic [RST_CNT_W-1:0] RST_CNT_ZERO = 8'h00;
	localparam logic [RST_CNT_W-1:0] RST_CNT_ONE  = 8'h01;
	localparam logic [RST_CNT_W-1:0] RST_CNT_MAX  = RST_CNT_W'(RST_MIN_CYCLES);

endpackage

//--- rtl/src_sync.sv
`timescale 1ns/10ps
// three-stage input synchroniser; the filtered level moves only when stages two and three agree
module src_sync (
	input  wire logic i_sys_clk,
	input  wire logic i_resetn,
	input  wire logic i_async,
	output logic      o_level
);

	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// idles high like the pulled-up pin, so no false low follows reset
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_level <= 1'b1;
		end else if (s2_q == s3_q) begin
			o_level <= s3_q;
		end
	end

endmodule

//--- tb/src_chk.sv
`timescale 1ns/10ps
module src_chk (
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_resetn,
	input  wire logic                       i_rst_pin,
	input  wire logic                       i_rst_pin_disable,
	input  wire logic                       i_sleep_enable,
	input  wire logic                       i_sleep_req,
	input  wire logic [1:0]                 i_sleep_mode,
	input  wire logic                       i_irq,
	input  wire logic                       o_sys_rstn,
	input  wire logic                       o_cpu_clk_en,
	input  wire logic                       o_mem_clk_en,
	input  wire logic                       o_timer_clk_en,
	input  wire logic                       o_adc_clk_en,
	input  wire logic                       o_acmp_clk_en,
	input  wire logic                       o_irq_clk_en,
	input  wire logic                       o_io_clk_en,
	input  wire logic                       o_sleeping,
	input  wire logic                       o_wake,
	input  wire logic [src_pkg::GPIO_W-1:0] o_six_general_io_lines_oe
);
	logic take;
	logic [6:0] cen;
	assign take = i_sleep_enable && i_sleep_req && !o_sleeping && !o_wake && o_sys_rstn;
	assign cen = {o_cpu_clk_en, o_mem_clk_en, o_timer_clk_en, o_adc_clk_en, o_acmp_clk_en, o_irq_clk_en, o_io_clk_en};
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	property p_idle; take && i_sleep_mode == 2'h0 |-> ##2 cen == 7'h3f; endproperty
	a_idle: assert property (p_idle) else $error("idle gating wrong");
	property p_adcq; take && i_sleep_mode == 2'h1 |-> ##2 cen == 7'h0a; endproperty
	a_adcq: assert property (p_adcq) else $error("adc quiet gating wrong");
	property p_pdown; take && i_sleep_mode == 2'h3 |-> ##2 cen == 7'h00 && o_sleeping; endproperty
	a_pdown: assert property (p_pdown) else $error("power-down gating wrong");
	property p_refuse; take && i_sleep_mode == 2'h2 |=> !o_sleeping; endproperty
	a_refuse: assert property (p_refuse) else $error("illegal mode entered");
	property p_stay; o_sleeping && !i_irq && !o_wake && o_sys_rstn |=> o_sleeping || !o_sys_rstn; endproperty
	a_stay: assert property (p_stay) else $error("left sleep without cause");
	property p_wake; o_sleeping && i_irq && !o_wake |=> o_wake ##1 (!o_sleeping && cen == 7'h7f); endproperty
	a_wake: assert property (p_wake) else $error("wake sequence wrong");
	property p_tri; !o_sys_rstn |-> o_six_general_io_lines_oe == '0; endproperty
	a_tri: assert property (p_tri) else $error("io driven in reset");
	property p_pin; !i_rst_pin && !i_rst_pin_disable |-> !o_sys_rstn; endproperty
	a_pin: assert property (p_pin) else $error("pin reset missing");
	c_sleep: cover property (take);
	c_wake: cover property (o_wake);
	c_pin: cover property (!i_rst_pin && !o_sys_rstn);
endmodule

//--- tb/src_wake_src.sv
`timescale 1ns/10ps
module src_wake_src (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_go,
	input  wire logic       i_irq_go,
	input  wire logic [3:0] i_lag,
	output logic            o_rst_pin,
	output logic            o_irq
);
	initial begin
		o_rst_pin = 1'b1;
		o_irq = 1'b0;
	end
	// pulled up between pulses; low pulse is the minimum plus margin
	always @(posedge i_sys_clk) begin
		if (i_rst_go) begin
			#1 o_rst_pin = 1'b0;
			repeat (src_pkg::RST_MIN_CYCLES + 5) @(posedge i_sys_clk);
			#1 o_rst_pin = 1'b1;
		end
	end
	// level raised after a lag, held past the wake edge
	always @(posedge i_sys_clk) begin
		if (i_irq_go) begin
			repeat (i_lag) @(posedge i_sys_clk);
			#1 o_irq = 1'b1;
			repeat (3) @(posedge i_sys_clk);
			#1 o_irq = 1'b0;
		end
	end
endmodule

//--- tb/src_sleep_reset_ctrl_tb_top.sv
`timescale 1ns/10ps
module src_sleep_reset_ctrl_tb_top;
	logic i_sys_clk, i_resetn, i_rst_pin, i_rst_pin_disable, i_rst_pin_out, i_rst_pin_oe, i_irq;
	logic i_sleep_enable, i_sleep_req, rst_go, irq_go, o_sys_rstn, o_sleeping, o_wake;
	logic o_cpu_clk_en, o_mem_clk_en, o_timer_clk_en, o_adc_clk_en, o_acmp_clk_en, o_irq_clk_en, o_io_clk_en;
	logic o_rst_pin_io_out, o_rst_pin_io_oe;
	logic [1:0] i_sleep_mode;
	logic [3:0] lag;
	logic [6:0] cen;
	logic [src_pkg::GPIO_W-1:0] i_gpio_out, i_gpio_oe, o_six_general_io_lines, o_six_general_io_lines_oe;
	int n_fail, checks_done, cycles;
	assign cen = {o_cpu_clk_en, o_mem_clk_en, o_timer_clk_en, o_adc_clk_en, o_acmp_clk_en, o_irq_clk_en, o_io_clk_en};
	src_sleep_reset_ctrl uut (
		.i_sys_clk                 (i_sys_clk),
		.i_resetn                  (i_resetn),
		.i_rst_pin                 (i_rst_pin),
		.i_rst_pin_disable         (i_rst_pin_disable),
		.i_rst_pin_out             (i_rst_pin_out),
		.i_rst_pin_oe              (i_rst_pin_oe),
		.i_sleep_enable            (i_sleep_enable),
		.i_sleep_req               (i_sleep_req),
		.i_sleep_mode              (i_sleep_mode),
		.i_irq                     (i_irq),
		.i_gpio_out                (i_gpio_out),
		.i_gpio_oe                 (i_gpio_oe),
		.o_sys_rstn                (o_sys_rstn),
		.o_cpu_clk_en              (o_cpu_clk_en),
		.o_mem_clk_en              (o_mem_clk_en),
		.o_timer_clk_en            (o_timer_clk_en),
		.o_adc_clk_en              (o_adc_clk_en),
		.o_acmp_clk_en             (o_acmp_clk_en),
		.o_irq_clk_en              (o_irq_clk_en),
		.o_io_clk_en               (o_io_clk_en),
		.o_sleeping                (o_sleeping),
		.o_wake                    (o_wake),
		.o_six_general_io_lines    (o_six_general_io_lines),
		.o_six_general_io_lines_oe (o_six_general_io_lines_oe),
		.o_rst_pin_io_out          (o_rst_pin_io_out),
		.o_rst_pin_io_oe           (o_rst_pin_io_oe)
	);
	src_wake_src partner (.i_sys_clk(i_sys_clk), .i_rst_go(rst_go), .i_irq_go(irq_go), .i_lag(lag),
		.o_rst_pin(i_rst_pin), .o_irq(i_irq));
	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task tally_and_finish;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			n_fail++;
			tally_and_finish;
		end
	end
	task sleep_wake(input logic [1:0] m, input logic [6:0] exp, input logic [3:0] l);
		i_sleep_mode = m;
		i_sleep_req = 1'b1;
		step(1);
		i_sleep_req = 1'b0;
		step(1);
		chk(o_sleeping, 7'h01);
		step(1);
		chk(cen, exp);
		step(4);
		chk({o_sleeping, cen}, {1'b1, exp});
		lag = l;
		irq_go = 1'b1;
		step(1);
		irq_go = 1'b0;
		for (int i = 0; i < 20 && o_wake !== 1'b1; i++) step(1);
		chk(o_wake, 7'h01);
		step(1);
		chk({o_sleeping, cen}, 8'h7f);
		step(3);
	endtask
	task refuse;
		i_sleep_mode = 2'h2;
		i_sleep_req = 1'b1;
		step(1);
		i_sleep_req = 1'b0;
		i_sleep_enable = 1'b0;
		step(2);
		chk(o_sleeping, 7'h00);
		i_sleep_mode = 2'h0;
		i_sleep_req = 1'b1;
		step(1);
		i_sleep_req = 1'b0;
		step(2);
		chk(o_sleeping, 7'h00);
		i_sleep_enable = 1'b1;
	endtask
	task pin_reset(input logic dis);
		i_rst_pin_disable = dis;
		i_rst_pin_oe = dis;
		i_rst_pin_out = 1'b1;
		step(2);
		rst_go = 1'b1;
		step(1);
		rst_go = 1'b0;
		step(2);
		chk({o_sys_rstn, o_six_general_io_lines_oe}, dis ? 7'h7f : 7'h00);
		step(src_pkg::RST_MIN_CYCLES);
		chk({o_rst_pin_io_oe, o_rst_pin_io_out}, {dis, dis});
		for (int i = 0; i < 40 && o_sys_rstn !== 1'b1; i++) step(1);
		step(3);
		chk({o_sys_rstn, o_six_general_io_lines_oe}, 7'h7f);
		chk({o_rst_pin_io_oe, o_rst_pin_io_out, o_six_general_io_lines}, {dis, dis, 6'h2a});
		for (int i = 0; i < 20 && i_rst_pin !== 1'b1; i++) step(1);
		step(6);
		i_rst_pin_disable = 1'b0;
		i_rst_pin_oe = 1'b0;
		i_rst_pin_out = 1'b0;
		step(2);
	endtask
	initial begin
		{i_resetn, i_rst_pin_disable, i_rst_pin_out, i_rst_pin_oe, i_sleep_req, rst_go, irq_go} = '0;
		i_sleep_enable = 1'b1;
		i_sleep_mode = 2'h0;
		lag = 4'h0;
		i_gpio_out = 6'h2a;
		i_gpio_oe = 6'h3f;
		step(6);
		i_resetn = 1'b1;
		step(4);
		sleep_wake(2'h0, 7'h3f, 4'h0);
		sleep_wake(2'h1, 7'h0a, 4'h3);
		sleep_wake(2'h3, 7'h00, 4'h7);
		refuse;
		pin_reset(1'b0);
		pin_reset(1'b1);
		tally_and_finish;
	end
endmodule
bind src_sleep_reset_ctrl src_chk u_chk (
	.i_sys_clk                 (i_sys_clk),
	.i_resetn                  (i_resetn),
	.i_rst_pin                 (i_rst_pin),
	.i_rst_pin_disable         (i_rst_pin_disable),
	.i_sleep_enable            (i_sleep_enable),
	.i_sleep_req               (i_sleep_req),
	.i_sleep_mode              (i_sleep_mode),
	.i_irq                     (i_irq),
	.o_sys_rstn                (o_sys_rstn),
	.o_cpu_clk_en              (o_cpu_clk_en),
	.o_mem_clk_en              (o_mem_clk_en),
	.o_timer_clk_en            (o_timer_clk_en),
	.o_adc_clk_en              (o_adc_clk_en),
	.o_acmp_clk_en             (o_acmp_clk_en),
	.o_irq_clk_en              (o_irq_clk_en),
	.o_io_clk_en               (o_io_clk_en),
	.o_sleeping                (o_sleeping),
	.o_wake                    (o_wake),
	.o_six_general_io_lines_oe (o_six_general_io_lines_oe)
);
